// >>> rtl/freq_wd_pkg.sv
// package of constants and types for the frequency select watchdog block
package freq_wd_pkg;
   // =========================================================
   // field widths
   localparam int STRAP_W = 5;
   localparam int NUM_W = 8;
   localparam int DEN_W = 7;
   localparam int COUNT_W = 5;
   // =========================================================
   // reset values
   localparam logic PROG_EN_RST = 1'b0;
   localparam logic OVERRIDE_RST = 1'b0;
   localparam logic [NUM_W-1:0] NUM_RST = 8'h00;
   localparam logic [DEN_W-1:0] DEN_RST = 7'h00;
   // =========================================================
   // formula offset added to numerator and denominator
   localparam logic [8:0] FORMULA_OFFSET = 9'h003;
   // =========================================================
   // timing
   localparam longint CLK_HZ = 25000000;
   localparam longint UNIT_SHORT_MS = 150;
   localparam longint UNIT_LONG_MS = 2500;
   localparam longint UNIT_SHORT_CYC = CLK_HZ / 1000 * UNIT_SHORT_MS;
   localparam longint UNIT_LONG_CYC = CLK_HZ / 1000 * UNIT_LONG_MS;
   localparam int PULSE_CYC = 16;
   localparam int PRESCALE_W = 27;
   // =========================================================
   // watchdog states
   typedef enum logic [1:0] {WD_IDLE, WD_ARMED, WD_COUNT, WD_LOCKED} wd_state_t;
endpackage

// >>> rtl/freq_wd_if.sv
// interface carrying events and busy status between the top and its helpers
`timescale 1ns/1ns
interface freq_wd_if;
   logic tick;
   logic start;
   logic [1:0] pulse_req;
   logic pulse_busy;
   modport top (output start, output pulse_req, input tick, input pulse_busy);
   modport tick_gen (input start, output tick);
   modport pulser (input pulse_req, output pulse_busy);
endinterface

// >>> rtl/wd_prescaler.sv
// prescaler that divides the reference clock into watchdog ticks
`timescale 1ns/1ns
module wd_prescaler #(
   parameter logic [26:0] SHORT_CYC = 27'(freq_wd_pkg::UNIT_SHORT_CYC),
   parameter logic [26:0] LONG_CYC = 27'(freq_wd_pkg::UNIT_LONG_CYC)
)
(
   input wire logic i_mclk,
   input wire logic i_arst_n,
   input wire logic i_long_unit,
   freq_wd_if.tick_gen bus
);
   typedef struct packed
   {
      logic [26:0] cnt;
      logic tick;
   } st_t;
   st_t s_q;
   st_t s_d;
   logic [26:0] limit;
   // =========================================================
   // divider, restarted on each countdown start so the first unit is whole
   always_comb
   begin
      s_d = s_q;
      limit = i_long_unit ? LONG_CYC : SHORT_CYC;
      s_d.tick = 1'b0;
      if (bus.start)
         s_d.cnt = 27'h0000000;
      else if (s_q.cnt >= limit - 27'h0000001)
      begin
         s_d.cnt = 27'h0000000;
         s_d.tick = 1'b1;
      end
      else
         s_d.cnt = s_q.cnt + 27'h0000001;
   end
   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         s_q <= '0;
      else
         s_q <= s_d;
   end
   assign bus.tick = s_q.tick;
endmodule

// >>> rtl/reset_pulser.sv
// fixed width reset pulse generator, one pulse per request taken while idle
`timescale 1ns/1ns
module reset_pulser #(
   parameter int WIDTH = freq_wd_pkg::PULSE_CYC
)
(
   input wire logic i_mclk,
   input wire logic i_arst_n,
   freq_wd_if.pulser bus,
   output logic o_reset_n
);
   typedef struct packed
   {
      logic [7:0] cnt;
      logic active;
   } st_t;
   st_t s_q;
   st_t s_d;
   // =========================================================
   // a request during a pulse is merged into it rather than stretching it
   always_comb
   begin
      s_d = s_q;
      if (s_q.active)
      begin
         if (s_q.cnt == 8'(WIDTH - 1))
            s_d.active = 1'b0;
         else
            s_d.cnt = s_q.cnt + 8'h01;
      end
      else if (|bus.pulse_req)
      begin
         s_d.active = 1'b1;
         s_d.cnt = 8'h00;
      end
   end
   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         s_q <= '0;
      else
         s_q <= s_d;
   end
   assign o_reset_n = ~s_q.active;
   assign bus.pulse_busy = s_q.active;
endmodule

// >>> rtl/freq_select_watchdog_recovery.sv
// frequency source selection with watchdog and locked recovery mode
//
// Overview of operation
// - programmable off: strap pins when override 0, software choice bits when 1
// - programmable on: cpu frequency from numerator, denominator and gear constant
// - programmable on: gear and ratio from straps (override 0) or choice bits (1)
// - write to numerator or denominator starts a frequency load
// - time-out switches to recovery: straps (choice 0) or recovery values (1)
// - recovery values use override-chosen ratio; writing either starts a load, except while locked, where the write is dropped and no load starts
// - clearing watchdog arm stops timer, reloads count, releases recovery lock
// - arming enables the timer; it counts only after a frequency change
// - time-out issues reset, loads recovery frequency, enters locked mode
// - time-out flag reads 1 after time-out; write 1 clears, 0 does nothing
// - 5-bit count sets period in units; reaching zero sets time-out flag
// - unit select 0 gives 150 ms, 1 gives 2.5 s
// - time-out reset pulse when reset-on-timeout enable is 1, or via the recovery load when reset-on-change enable is 1
// - reset pulse after each frequency change when reset-on-change enable is 1
// - programmable settings for 50 to 248 MHz are accepted unchanged
// - after reset programmable enable and override are 0, straps govern
// - cpu frequency is gear times (numerator+3) over (denominator+3)
`timescale 1ns/1ns
module freq_select_watchdog_recovery #(
   parameter logic [26:0] UNIT_SHORT_CYC = 27'(freq_wd_pkg::UNIT_SHORT_CYC),
   parameter logic [26:0] UNIT_LONG_CYC = 27'(freq_wd_pkg::UNIT_LONG_CYC)
)
(
   input wire logic i_mclk,
   input wire logic i_arst_n,
   input wire logic [4:0] i_strap_pins,
   input wire logic i_prog_enable_wr,
   input wire logic i_prog_enable_val,
   input wire logic i_strap_override_wr,
   input wire logic i_strap_override_val,
   input wire logic i_choice_wr,
   input wire logic [4:0] i_choice_val,
   input wire logic i_cpu_numerator_wr,
   input wire logic [7:0] i_cpu_numerator_val,
   input wire logic i_cpu_denominator_wr,
   input wire logic [6:0] i_cpu_denominator_val,
   input wire logic i_recovery_source_choice,
   input wire logic i_recovery_numerator_wr,
   input wire logic [7:0] i_recovery_numerator_val,
   input wire logic i_recovery_denominator_wr,
   input wire logic [6:0] i_recovery_denominator_val,
   input wire logic i_watchdog_arm,
   input wire logic i_timeout_flag_wr,
   input wire logic i_timeout_flag_val,
   input wire logic [4:0] i_timeout_count,
   input wire logic i_tick_unit_choice,
   input wire logic i_reset_on_timeout_enable,
   input wire logic i_reset_on_change_enable,
   output logic o_prog_active,
   output logic [4:0] o_ratio_select,
   output logic [7:0] o_numerator,
   output logic [6:0] o_denominator,
   output logic [8:0] o_mult_term,
   output logic [8:0] o_div_term,
   output logic o_freq_load,
   output logic o_timeout_flag,
   output logic o_locked,
   output logic [4:0] o_count_left,
   output logic o_prog_enable,
   output logic o_strap_override,
   output logic [4:0] o_choice,
   output logic o_sys_reset_n
);
   // =========================================================
   // state
   typedef struct packed
   {
      logic straps_taken;
      logic [4:0] strap_latch;
      logic prog_en;
      logic override;
      logic [4:0] choice;
      logic [7:0] cpu_num;
      logic [6:0] cpu_den;
      logic [7:0] rec_num;
      logic [6:0] rec_den;
      freq_wd_pkg::wd_state_t wd;
      logic [4:0] count;
      logic flag;
      logic arm_prev;
      logic [4:0] sel_out;
      logic [7:0] num_out;
      logic [6:0] den_out;
      logic prog_out;
      logic load;
      // a setting write is waiting to be applied on the next edge
      logic pend;
   } st_t;
   st_t s_q;
   st_t s_d;
   freq_wd_if link ();
   logic change;
   logic timeout;
   logic rec_wr;
   logic [4:0] ratio_src;
   // =========================================================
   // helpers
   wd_prescaler #(
      .SHORT_CYC(UNIT_SHORT_CYC),
      .LONG_CYC(UNIT_LONG_CYC)
   ) u_prescaler (
      .i_mclk(i_mclk),
      .i_arst_n(i_arst_n),
      .i_long_unit(i_tick_unit_choice),
      .bus(link.tick_gen)
   );
   reset_pulser u_pulser (
      .i_mclk(i_mclk),
      .i_arst_n(i_arst_n),
      .bus(link.pulser),
      .o_reset_n(o_sys_reset_n)
   );
   // =========================================================
   // next state
   always_comb
   begin
      s_d = s_q;
      change = 1'b0;
      timeout = 1'b0;
      rec_wr = 1'b0;
      s_d.load = 1'b0;
      s_d.pend = 1'b0;
      s_d.arm_prev = i_watchdog_arm;
      // straps are caught once, on the first clock after reset release
      if (!s_q.straps_taken)
      begin
         s_d.straps_taken = 1'b1;
         s_d.strap_latch = i_strap_pins;
      end
      // frequency writes are dropped while locked in recovery
      if (s_q.wd != freq_wd_pkg::WD_LOCKED)
      begin
         if (i_prog_enable_wr)
         begin
            s_d.prog_en = i_prog_enable_val;
            change = 1'b1;
         end
         if (i_strap_override_wr)
         begin
            s_d.override = i_strap_override_val;
            change = 1'b1;
         end
         if (i_choice_wr)
         begin
            s_d.choice = i_choice_val;
            change = 1'b1;
         end
         if (i_cpu_numerator_wr)
         begin
            s_d.cpu_num = i_cpu_numerator_val;
            change = 1'b1;
         end
         if (i_cpu_denominator_wr)
         begin
            s_d.cpu_den = i_cpu_denominator_val;
            change = 1'b1;
         end
         if (i_recovery_numerator_wr)
         begin
            s_d.rec_num = i_recovery_numerator_val;
            rec_wr = 1'b1;
            // a recovery write is a frequency change too, so it starts the timer
            change = 1'b1;
         end
         if (i_recovery_denominator_wr)
         begin
            s_d.rec_den = i_recovery_denominator_val;
            rec_wr = 1'b1;
            change = 1'b1;
         end
      end
      // watchdog sequencing
      case (s_q.wd)
         freq_wd_pkg::WD_IDLE:
         begin
            s_d.count = i_timeout_count;
            if (i_watchdog_arm)
               s_d.wd = freq_wd_pkg::WD_ARMED;
         end
         freq_wd_pkg::WD_ARMED:
         begin
            s_d.count = i_timeout_count;
            if (!i_watchdog_arm)
               s_d.wd = freq_wd_pkg::WD_IDLE;
            else if (change)
               s_d.wd = freq_wd_pkg::WD_COUNT;
         end
         freq_wd_pkg::WD_COUNT:
         begin
            if (!i_watchdog_arm)
            begin
               s_d.wd = freq_wd_pkg::WD_IDLE;
               s_d.count = i_timeout_count;
            end
            else if (s_q.count == 5'h00 || (link.tick && s_q.count == 5'h01))
            begin
               timeout = 1'b1;
               s_d.count = 5'h00;
               s_d.wd = freq_wd_pkg::WD_LOCKED;
            end
            else if (link.tick)
               s_d.count = s_q.count - 5'h01;
         end
         freq_wd_pkg::WD_LOCKED:
         begin
            if (!i_watchdog_arm)
            begin
               s_d.wd = freq_wd_pkg::WD_IDLE;
               s_d.count = i_timeout_count;
            end
         end
         default:
            s_d.wd = freq_wd_pkg::WD_IDLE;
      endcase
      // time-out flag: set wins over a same-cycle clear
      if (i_timeout_flag_wr && i_timeout_flag_val)
         s_d.flag = 1'b0;
      if (timeout)
         s_d.flag = 1'b1;
      // ratio source for gear and group ratio follows override
      ratio_src = s_q.override ? s_q.choice : s_q.strap_latch;
      if (timeout)
      begin
         s_d.load = 1'b1;
         if (i_recovery_source_choice)
         begin
            s_d.prog_out = 1'b1;
            s_d.num_out = s_q.rec_num;
            s_d.den_out = s_q.rec_den;
            s_d.sel_out = ratio_src;
         end
         else
         begin
            s_d.prog_out = 1'b0;
            s_d.sel_out = s_q.strap_latch;
         end
      end
      else if (s_q.wd != freq_wd_pkg::WD_LOCKED && (change || !s_q.straps_taken))
      begin
         // settings applied one cycle after the write lands in state;
         // the load strobe is held back so that it rises together with
         // the applied outputs, never one cycle ahead of them
         s_d.pend = s_q.straps_taken;
      end
      else if (s_q.wd != freq_wd_pkg::WD_LOCKED)
      begin
         // a pending write becomes a load pulse in the apply cycle, so the
         // change reset pulse follows the new frequency and not the old one
         s_d.load = s_q.pend;
         s_d.prog_out = s_q.prog_en;
         s_d.sel_out = ratio_src;
         s_d.num_out = s_q.cpu_num;
         s_d.den_out = s_q.cpu_den;
      end
      if (rec_wr && s_q.wd == freq_wd_pkg::WD_LOCKED)
         s_d.load = 1'b1;
   end
   // =========================================================
   // registers
   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         s_q <= '0;
         s_q.prog_en <= freq_wd_pkg::PROG_EN_RST;
         s_q.override <= freq_wd_pkg::OVERRIDE_RST;
         s_q.cpu_num <= freq_wd_pkg::NUM_RST;
         s_q.cpu_den <= freq_wd_pkg::DEN_RST;
         s_q.wd <= freq_wd_pkg::WD_IDLE;
      end
      else
         s_q <= s_d;
   end
   // =========================================================
   // pulse requests: one per time-out, one per frequency change
   assign link.pulse_req[0] = timeout & i_reset_on_timeout_enable;
   assign link.pulse_req[1] = s_q.load & ~timeout & i_reset_on_change_enable;
   assign link.start = (s_q.wd == freq_wd_pkg::WD_ARMED) & change;
   // =========================================================
   // outputs; multiplier terms feed the pll as gear*(n+3)/(m+3)
   // all applied values come straight from flops, so the pll never sees a
   // half-written numerator and denominator pair within one cycle
   assign o_prog_active = s_q.prog_out;
   assign o_ratio_select = s_q.sel_out;
   assign o_numerator = s_q.num_out;
   assign o_denominator = s_q.den_out;
   assign o_mult_term = {1'b0, s_q.num_out} + freq_wd_pkg::FORMULA_OFFSET;
   assign o_div_term = {2'b00, s_q.den_out} + freq_wd_pkg::FORMULA_OFFSET;
   assign o_freq_load = s_q.load;
   assign o_timeout_flag = s_q.flag;
   assign o_locked = (s_q.wd == freq_wd_pkg::WD_LOCKED);
   assign o_count_left = s_q.count;
   assign o_prog_enable = s_q.prog_en;
   assign o_strap_override = s_q.override;
   assign o_choice = s_q.choice;
endmodule

// >>> testbench/fsw_chk.sv
// assertion checker for the frequency select watchdog block
`timescale 1ns/1ns
module fsw_chk
(
   input wire logic i_mclk,
   input wire logic i_arst_n,
   input wire logic i_cpu_numerator_wr,
   input wire logic i_cpu_denominator_wr,
   input wire logic i_watchdog_arm,
   input wire logic i_timeout_flag_wr,
   input wire logic i_timeout_flag_val,
   input wire logic i_reset_on_timeout_enable,
   input wire logic i_reset_on_change_enable,
   input wire logic [7:0] o_numerator,
   input wire logic [6:0] o_denominator,
   input wire logic [8:0] o_mult_term,
   input wire logic [8:0] o_div_term,
   input wire logic o_freq_load,
   input wire logic o_timeout_flag,
   input wire logic o_locked,
   input wire logic o_sys_reset_n
);
   // =========
   // helpers
   // low cycles of the reset output, so the width is checked without long repeats
   logic [5:0] low_q;
   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         low_q <= 6'h00;
      else
         low_q <= o_sys_reset_n ? 6'h00 : low_q + 6'h01;
   end
   default clocking @(posedge i_mclk);
   endclocking
   default disable iff (!i_arst_n);
   sequence s_cpu_write;
      (i_cpu_numerator_wr || i_cpu_denominator_wr) && !o_locked;
   endsequence
   // three quiet samples cover the pulse request pipeline
   sequence s_quiet;
      (!i_reset_on_change_enable && !i_reset_on_timeout_enable) [*3];
   endsequence
   // =========
   // assertions
   AST_LOAD_AFTER_WRITE: assert property (s_cpu_write |-> ##2 o_freq_load)
      else $error("no load two cycles after a setting write");
   AST_LOCK_HOLDS: assert property (o_locked && i_watchdog_arm |=>
      $stable(o_numerator) && $stable(o_denominator))
      else $error("applied setting moved while locked");
   AST_TIMEOUT_ENTRY: assert property ($rose(o_timeout_flag) |-> o_locked && o_freq_load)
      else $error("time-out without lock and recovery load");
   AST_FLAG_CLEAR: assert property (o_timeout_flag && i_timeout_flag_wr &&
      i_timeout_flag_val |=> !o_timeout_flag)
      else $error("flag not cleared by write of one");
   AST_FLAG_KEEP: assert property (o_timeout_flag &&
      !(i_timeout_flag_wr && i_timeout_flag_val) |=> o_timeout_flag)
      else $error("flag dropped without a clearing write");
   AST_UNLOCK: assert property (!i_watchdog_arm |=> !o_locked)
      else $error("still locked with the watchdog disarmed");
   AST_PULSE_WIDTH: assert property ($rose(o_sys_reset_n) |->
      low_q == 6'(freq_wd_pkg::PULSE_CYC))
      else $error("reset pulse width wrong");
   AST_CHANGE_PULSE: assert property (o_freq_load && i_reset_on_change_enable &&
      low_q == 6'h00 |-> ##[0:2] !o_sys_reset_n)
      else $error("no reset pulse after a change");
   AST_QUIET_RESET: assert property (s_quiet ##0 o_sys_reset_n |=> o_sys_reset_n)
      else $error("reset pulse with both enables off");
   AST_FORMULA: assert property (o_mult_term == {1'b0, o_numerator} +
      freq_wd_pkg::FORMULA_OFFSET && o_div_term == {2'b00, o_denominator} +
      freq_wd_pkg::FORMULA_OFFSET)
      else $error("formula terms wrong");
endmodule
bind freq_select_watchdog_recovery fsw_chk i_fsw_chk (.*);

// >>> testbench/host_model.sv
// host side model issuing setting writes to the watchdog block
`timescale 1ns/1ns
module host_model
(
   input wire logic i_mclk,
   output logic i_prog_enable_wr = 1'b0, i_prog_enable_val = 1'b0,
   output logic i_strap_override_wr = 1'b0, i_strap_override_val = 1'b0,
   output logic i_choice_wr = 1'b0,
   output logic [4:0] i_choice_val = 5'h00,
   output logic i_cpu_numerator_wr = 1'b0, i_cpu_denominator_wr = 1'b0,
   output logic [7:0] i_cpu_numerator_val = 8'h00,
   output logic [6:0] i_cpu_denominator_val = 7'h00,
   output logic i_recovery_numerator_wr = 1'b0, i_recovery_denominator_wr = 1'b0,
   output logic [7:0] i_recovery_numerator_val = 8'h00,
   output logic [6:0] i_recovery_denominator_val = 7'h00,
   output logic i_recovery_source_choice = 1'b0, i_watchdog_arm = 1'b0,
   output logic i_timeout_flag_wr = 1'b0, i_timeout_flag_val = 1'b0,
   output logic [4:0] i_timeout_count = 5'h00,
   output logic i_tick_unit_choice = 1'b0, i_reset_on_timeout_enable = 1'b0,
   output logic i_reset_on_change_enable = 1'b0
);
   // =========
   // write cycles
   // strobes drop one edge later so each write is taken exactly once
   task automatic end_wr;
      @(posedge i_mclk);
      #1;
      {i_prog_enable_wr, i_strap_override_wr, i_choice_wr, i_timeout_flag_wr} = 4'h0;
      {i_cpu_numerator_wr, i_cpu_denominator_wr} = 2'h0;
      {i_recovery_numerator_wr, i_recovery_denominator_wr} = 2'h0;
   endtask
   // both halves in one cycle, so only one frequency load starts
   task automatic set_nd(input logic rec, input logic [7:0] n, input logic [6:0] d);
      @(posedge i_mclk);
      #1;
      {i_recovery_numerator_wr, i_recovery_denominator_wr} = {rec, rec};
      {i_cpu_numerator_wr, i_cpu_denominator_wr} = {!rec, !rec};
      {i_recovery_numerator_val, i_cpu_numerator_val} = {n, n};
      {i_recovery_denominator_val, i_cpu_denominator_val} = {d, d};
      end_wr();
   endtask
   // mode settings written together
   task automatic set_cfg(input logic pe, input logic ov, input logic [4:0] ch);
      @(posedge i_mclk);
      #1;
      {i_prog_enable_wr, i_strap_override_wr, i_choice_wr} = 3'h7;
      {i_prog_enable_val, i_strap_override_val, i_choice_val} = {pe, ov, ch};
      end_wr();
   endtask
   task automatic flag_wr(input logic v);
      @(posedge i_mclk);
      #1;
      {i_timeout_flag_wr, i_timeout_flag_val} = {1'b1, v};
      end_wr();
   endtask
   // level settings; arm, count, unit, both reset enables and recovery source in one cycle
   task automatic levels(input logic arm, input logic [4:0] cnt, input logic unit,
      input logic rto, input logic rch, input logic rsrc);
      @(posedge i_mclk);
      #1;
      i_watchdog_arm = arm;
      {i_timeout_count, i_tick_unit_choice} = {cnt, unit};
      {i_reset_on_timeout_enable, i_reset_on_change_enable} = {rto, rch};
      i_recovery_source_choice = rsrc;
   endtask
endmodule

// >>> testbench/testbench.sv
// self-checking bench for the frequency select watchdog block
`timescale 1ns/1ns
module testbench;
   // =========
   // signals
   logic i_mclk = 1'b0;
   logic i_arst_n = 1'b0;
   logic [4:0] i_strap_pins = 5'h0b;
   logic i_prog_enable_wr, i_prog_enable_val, i_strap_override_wr, i_strap_override_val;
   logic i_choice_wr, i_cpu_numerator_wr, i_cpu_denominator_wr, i_recovery_source_choice;
   logic i_recovery_numerator_wr, i_recovery_denominator_wr, i_watchdog_arm;
   logic i_timeout_flag_wr, i_timeout_flag_val, i_tick_unit_choice;
   logic i_reset_on_timeout_enable, i_reset_on_change_enable;
   logic [4:0] i_choice_val, i_timeout_count, o_ratio_select, o_choice, o_count_left;
   logic [7:0] i_cpu_numerator_val, i_recovery_numerator_val, o_numerator;
   logic [6:0] i_cpu_denominator_val, i_recovery_denominator_val, o_denominator;
   logic [8:0] o_mult_term, o_div_term;
   logic o_prog_active, o_freq_load, o_timeout_flag, o_locked, o_prog_enable;
   logic o_strap_override, o_sys_reset_n;
   int error_cnt = 0;
   int checks = 0;
   int cyc = 0;
   int pulses = 0;
   int n;
   // short units keep the watchdog runs brief
   freq_select_watchdog_recovery #(
      .UNIT_SHORT_CYC(27'h00000a),
      .UNIT_LONG_CYC(27'h000028)
   )
   i_freq_select_watchdog_recovery (.*);
   host_model i_host_model (.*);
   always #20 i_mclk = ~i_mclk;
   // count reset pulses seen at the output
   always @(negedge o_sys_reset_n) pulses++;
   // hang guard
   always @(posedge i_mclk)
   begin
      cyc++;
      if (cyc == 1000)
      begin
         error_cnt++;
         give_verdict();
      end
   end
   // =========
   // tasks
   task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
      checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wait_cyc(input int k);
      repeat (k) @(posedge i_mclk);
      #1;
   endtask
   // wait for the flag, then check the delay against the unit count
   task automatic wait_flag(input int lo);
      n = 0;
      while (o_timeout_flag !== 1'b1 && n < 100)
      begin
         @(posedge i_mclk);
         #1;
         n++;
      end
      chk("timeout delay", 9'h001, {8'h00, n >= lo && n <= lo + 6});
   endtask
   task automatic give_verdict;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // =========
   // scenarios
   initial
   begin
      repeat (20) @(posedge i_mclk);
      #1;
      i_arst_n = 1'b1;
      wait_cyc(3);
      chk("prog_enable", 9'h000, o_prog_enable);
      chk("override", 9'h000, o_strap_override);
      chk("ratio straps", 9'h00b, o_ratio_select);
      i_host_model.set_cfg(1'b0, 1'b1, 5'h15);
      wait_cyc(3);
      chk("ratio choice", 9'h015, o_ratio_select);
      chk("choice readback", 9'h015, o_choice);
      chk("no pulses", 9'h000, 9'(pulses));
      i_host_model.set_cfg(1'b1, 1'b1, 5'h15);
      wait_cyc(3);
      i_host_model.levels(1'b0, 5'h02, 1'b0, 1'b1, 1'b1, 1'b1);
      i_host_model.set_nd(1'b0, 8'h6a, 7'h27);
      wait_cyc(3);
      chk("numerator", 9'h06a, o_numerator);
      chk("mult term", 9'h06d, o_mult_term);
      chk("div term", 9'h02a, o_div_term);
      chk("prog_active", 9'h001, o_prog_active);
      chk("ratio prog", 9'h015, o_ratio_select);
      chk("change pulses", 9'h001, 9'(pulses));
      wait_cyc(20);
      i_host_model.levels(1'b1, 5'h02, 1'b0, 1'b1, 1'b0, 1'b1);
      wait_cyc(30);
      chk("flag idle", 9'h000, o_timeout_flag);
      i_host_model.set_nd(1'b1, 8'h4d, 7'h30);
      wait_flag(18);
      chk("locked", 9'h001, o_locked);
      chk("rec numerator", 9'h04d, o_numerator);
      chk("rec denominator", 9'h030, o_denominator);
      wait_cyc(2);
      chk("timeout pulses", 9'h002, 9'(pulses));
      i_host_model.set_nd(1'b0, 8'h10, 7'h10);
      wait_cyc(3);
      chk("locked numerator", 9'h04d, o_numerator);
      i_host_model.flag_wr(1'b0);
      wait_cyc(2);
      chk("flag kept", 9'h001, o_timeout_flag);
      i_host_model.flag_wr(1'b1);
      wait_cyc(2);
      chk("flag cleared", 9'h000, o_timeout_flag);
      i_host_model.levels(1'b0, 5'h02, 1'b0, 1'b1, 1'b0, 1'b1);
      wait_cyc(2);
      chk("unlocked", 9'h000, o_locked);
      chk("count reload", 9'h002, o_count_left);
      wait_cyc(20);
      i_host_model.levels(1'b1, 5'h01, 1'b1, 1'b0, 1'b0, 1'b0);
      wait_cyc(2);
      i_host_model.set_nd(1'b0, 8'h6a, 7'h27);
      wait_flag(38);
      chk("rec ratio straps", 9'h00b, o_ratio_select);
      wait_cyc(20);
      chk("quiet pulses", 9'h002, 9'(pulses));
      give_verdict();
   end
endmodule
